// *** design/wdtsl_pkg.sv ***
/*
  shared constants for the watchdog with fuse-selected safety levels:
  clock rates, counter widths, register offsets, field positions.
  assumes a single 200 MHz system clock and an 8-bit register port.
*/
package wdtsl_pkg;

  // clocks: the watchdog oscillator is an enable pulse from a divider
  localparam int SYS_CLK_HZ = 200_000_000;
  localparam int WDT_OSC_HZ = 1_000_000;
  localparam int OSC_DIV    = SYS_CLK_HZ / WDT_OSC_HZ;
  localparam int DIV_W      = 8;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV - 1);

  // timeout counter: shortest period, doubled per select code
  localparam int WCNT_W = 22;
  localparam logic [WCNT_W-1:0] BASE_CYCLES = 22'h004000;

  // change-enable window length in system clock cycles
  localparam int CE_HOLD = 4;
  localparam logic [1:0] CE_LAST = 2'(CE_HOLD - 1);

  // register map
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CTL_OFF   = 4'h0;
  localparam logic [ADDR_W-1:0] RSTAT_OFF = 4'h1;

  // control fields
  localparam int CE_BIT  = 4;
  localparam int EN_BIT  = 3;
  localparam int SEL_LSB = 0;
  localparam int SEL_W   = 3;
  localparam logic [SEL_W-1:0] SEL_RST = 3'h0;

  // reset status fields
  localparam int FLAG_BIT = 3;

  typedef enum logic [2:0] {
    LVL0 = 3'b001,
    LVL1 = 3'b010,
    LVL2 = 3'b100
  } wdtsl_level_t;

endpackage

// *** design/wdtsl_top.sv ***
/*
  watchdog timer with fuse-selected safety levels, timed change
  sequence, period select and a sticky watchdog reset flag.
  assumes fuses and restart are synchronous to i_core_clk, and that
  the chip reset it requests comes back on i_rst_n.
*/
`timescale 1ns/1ps
`default_nettype none

module wdtsl_top
  import wdtsl_pkg::*;
#(
  parameter logic [WCNT_W-1:0] BASE_COUNT = BASE_CYCLES
) (
  // clock and resets
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_por,
  // fuses, high means programmed
  input  wire logic              i_always_on_fuse,
  input  wire logic              i_legacy_compat_fuse,
  // restart instruction strobe
  input  wire logic              i_restart,
  // register port
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [7:0]        i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [7:0]        o_rdata,
  // status and chip reset request
  output logic                   o_enabled,
  output logic                   o_wdt_reset
);

  wdtsl_level_t      level;
  wdtsl_level_t      fuse_level;
  logic              en;
  logic              ce;
  logic [1:0]        ce_cnt;
  logic [SEL_W-1:0]  sel;
  logic [DIV_W-1:0]  div_cnt;
  logic [WCNT_W-1:0] wcnt;
  logic              watchdog_reset_flag;

  logic              next_en;
  logic              next_ce;
  logic [1:0]        next_ce_cnt;
  logic [SEL_W-1:0]  next_sel;
  logic [DIV_W-1:0]  next_div;
  logic [WCNT_W-1:0] next_wcnt;
  logic              next_watchdog_reset_flag;
  logic [7:0]        next_rdata;

  // level decode; the compat fuse only matters when always-on is blank
  assign fuse_level = i_always_on_fuse     ? LVL2 :
                      i_legacy_compat_fuse ? LVL0 : LVL1;

  // register decode
  wire wr_ctl    = i_wr & (i_addr == CTL_OFF);
  wire wr_stat   = i_wr & (i_addr == RSTAT_OFF);
  wire rd_ctl    = i_rd & (i_addr == CTL_OFF);
  wire rd_stat   = i_rd & (i_addr == RSTAT_OFF);
  wire wd_ce     = i_wdata[CE_BIT];
  wire wd_en     = i_wdata[EN_BIT];
  wire [SEL_W-1:0] wd_sel = i_wdata[SEL_LSB +: SEL_W];
  wire lvl2      = (level == LVL2);
  wire lvl0      = (level == LVL0);

  // the timed sequence opens only on a write of both bits
  wire seq_start = wr_ctl & wd_ce & wd_en;

  // change-enable window
  always_comb begin
    next_ce     = ce;
    next_ce_cnt = ce_cnt;
    if (seq_start) begin
      next_ce     = 1'b1;
      next_ce_cnt = 2'h0;
    end else if (ce) begin
      next_ce_cnt = ce_cnt + 2'h1;
      if (ce_cnt == CE_LAST) begin
        next_ce = 1'b0;
      end
    end
  end

  // enable: set is free, clear needs the window, level two pins it
  always_comb begin
    case (level)
      LVL2:    next_en = 1'b1;
      LVL0,
      LVL1: begin
        if (wr_ctl) begin
          next_en = wd_en | (en & ~ce);
        end else begin
          next_en = en;
        end
      end
      default: next_en = en;
    endcase
  end

  // period select gated by the window outside level zero
  assign next_sel = (wr_ctl & (lvl0 | ce)) ? wd_sel : sel;

  // oscillator tick: one system cycle in every OSC_DIV
  wire tick = (div_cnt == DIV_LAST);
  assign next_div = tick ? '0 : div_cnt + {{(DIV_W-1){1'b0}}, 1'b1};

  // one clock only: requests act on the counter in the same cycle,
  // so no request can be lost between the two rates
  wire [WCNT_W-1:0] limit    = BASE_COUNT << sel;
  wire [WCNT_W-1:0] limit_m1 = limit - 22'h000001;
  // compare with >= so a period shortened mid-count fires on the next tick
  // instead of waiting for the counter to wrap
  wire timeout = tick & en & (wcnt >= limit_m1) & ~i_restart;

  always_comb begin
    if (i_restart | ~en | timeout) begin
      next_wcnt = '0;
    end else if (tick) begin
      next_wcnt = wcnt + 22'h000001;
    end else begin
      next_wcnt = wcnt;
    end
  end

  // sticky flag: a timeout in the clearing cycle still sets it
  assign next_watchdog_reset_flag = timeout |
                     (watchdog_reset_flag & ~(wr_stat & ~i_wdata[FLAG_BIT]));

  // read data stand only in the cycle after the strobe
  wire [7:0] ctl_view  = {3'h0, ce, en, sel};
  wire [7:0] stat_view = {4'h0, watchdog_reset_flag, 3'h0};
  assign next_rdata = rd_ctl  ? ctl_view  :
                      rd_stat ? stat_view : 8'h00;

  // chip reset restores fuse state and clears the counter
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      level  <= fuse_level;
      en     <= (fuse_level == LVL2);
      ce     <= 1'b0;
      ce_cnt <= 2'h0;
      sel    <= SEL_RST;
    end else begin
      en     <= next_en;
      ce     <= next_ce;
      ce_cnt <= next_ce_cnt;
      sel    <= next_sel;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      div_cnt     <= '0;
      wcnt        <= '0;
      o_wdt_reset <= 1'b0;
      o_rdata     <= 8'h00;
      // mirrors en through reset so level two never shows disabled
      o_enabled   <= (fuse_level == LVL2);
    end else begin
      div_cnt     <= next_div;
      wcnt        <= next_wcnt;
      o_wdt_reset <= timeout;
      o_rdata     <= next_rdata;
      o_enabled   <= next_en;
    end
  end

  // the flag survives every reset but power-on
  always_ff @(posedge i_core_clk) begin
    if (i_por) begin
      watchdog_reset_flag <= 1'b0;
    end else begin
      watchdog_reset_flag <= next_watchdog_reset_flag;
    end
  end

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  chk_rsvd_zero: assert property (
    o_rdata[7:5] == 3'h0
  ) else $error("reserved control bits read nonzero");

  chk_ce_hold: assert property (
    seq_start |=> ce [*4]
  ) else $error("change-enable dropped early");

  chk_ce_clear: assert property (
    (ce && ce_cnt == CE_LAST && !seq_start) |=> !ce
  ) else $error("change-enable not cleared after window");

  chk_en_set: assert property (
    (wr_ctl && wd_en) |=> en
  ) else $error("enable write did not enable");

  chk_en_locked: assert property (
    (wr_ctl && en && !ce) |=> en
  ) else $error("watchdog disabled without change-enable");

  chk_en_clear: assert property (
    (wr_ctl && !wd_en && ce && !lvl2) |=> !en
  ) else $error("timed disable did not take effect");

  chk_lvl2_on: assert property (
    lvl2 |-> (en && o_enabled)
  ) else $error("level two watchdog not enabled");

  chk_lvl2_read: assert property (
    (rd_ctl && lvl2) |=> o_rdata[EN_BIT]
  ) else $error("level two enable read as zero");

  chk_sel_lock: assert property (
    (wr_ctl && !ce && !lvl0) |=> $stable(sel)
  ) else $error("period changed without change-enable");

  chk_sel_free: assert property (
    (wr_ctl && lvl0) |=> (sel == $past(wd_sel))
  ) else $error("level zero period write not taken");

  chk_restart_clear: assert property (
    i_restart |=> (wcnt == '0)
  ) else $error("restart did not clear counter");

  chk_dis_clear: assert property (
    !en |=> (wcnt == '0)
  ) else $error("counter runs while disabled");

  chk_tick_space: assert property (
    tick |=> !tick [*8]
  ) else $error("oscillator tick too frequent");

  chk_timeout_fire: assert property (
    (tick && en && wcnt == limit_m1 && !i_restart) |=> o_wdt_reset
  ) else $error("elapsed period gave no reset");

  chk_pulse_once: assert property (
    o_wdt_reset |=> !o_wdt_reset
  ) else $error("reset pulse longer than one cycle");

  chk_flag_set: assert property (
    (timeout && !i_por) |=> watchdog_reset_flag
  ) else $error("watchdog flag not set on timeout");

  chk_ce_open: assert property (
    seq_start |=> (ce && ce_cnt == 2'h0)
  ) else $error("change-enable window did not restart");

  chk_ce_nostart: assert property (
    (wr_ctl && wd_ce && !wd_en && !ce) |=> !ce
  ) else $error("window opened without both bits");

  chk_lvl2_hold: assert property (
    (wr_ctl && lvl2) |=> en
  ) else $error("level two write changed enable");

  chk_level_hold: assert property (
    1'b1 |=> $stable(level)
  ) else $error("safety level changed outside reset");

  chk_tick_period: assert property (
    tick |-> ##200 tick
  ) else $error("oscillator tick period wrong");

  chk_count_hold: assert property (
    (en && !tick && !i_restart) |=> $stable(wcnt)
  ) else $error("counter moved between ticks");

  chk_restart_quiet: assert property (
    i_restart |=> !o_wdt_reset
  ) else $error("reset pulse despite restart");

  chk_timeout_off: assert property (
    !en |=> !o_wdt_reset
  ) else $error("reset pulse while disabled");

  chk_flag_hold: assert property (
    (watchdog_reset_flag && !i_por && !wr_stat) |=> watchdog_reset_flag
  ) else $error("watchdog flag lost");

  chk_flag_clear: assert property (
    (wr_stat && !i_wdata[FLAG_BIT] && !timeout) |=> !watchdog_reset_flag
  ) else $error("watchdog flag not cleared by write");

endmodule

`default_nettype wire

// *** sim/wdtsl_top_bench.sv ***
/*
  self-checking bench for the watchdog with safety levels.
  assumes the design's sim count of 16 and a 200-cycle oscillator tick.
*/
`timescale 1ns/1ps
`default_nettype none

module wdtsl_top_bench
  import wdtsl_pkg::*;
;
  logic              i_core_clk = 1'b0;
  logic              i_rst_n = 1'b0;
  logic              i_por = 1'b1;
  logic              i_always_on_fuse = 1'b0;
  logic              i_legacy_compat_fuse = 1'b0;
  logic              i_restart = 1'b0;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [7:0]        i_wdata = 8'h00;
  logic              i_wr = 1'b0;
  logic              i_rd = 1'b0;
  logic [7:0]        o_rdata;
  logic              o_enabled;
  logic              o_wdt_reset;
  int                errors = 0;
  int                check_count = 0;

  wdtsl_top #(.BASE_COUNT(22'h000010)) u_wdtsl_top (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_por(i_por),
    .i_always_on_fuse(i_always_on_fuse),
    .i_legacy_compat_fuse(i_legacy_compat_fuse),
    .i_restart(i_restart), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_enabled(o_enabled), .o_wdt_reset(o_wdt_reset));

  initial begin
    forever #2.5 i_core_clk = ~i_core_clk;
  end

  task automatic cmp(input string nm, input logic [15:0] s, e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // fuses are sampled while reset is low, so hold them through it
  task automatic rst(input logic af, lf);
    @(posedge i_core_clk);
    i_rst_n <= 1'b0;
    i_always_on_fuse <= af;
    i_legacy_compat_fuse <= lf;
    repeat (16) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    i_por <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 cmp("rdata", 16'(o_rdata), 16'(e));
  endtask

  task automatic no_pulse(input int n);
    logic s;
    s = 1'b0;
    repeat (n) begin
      @(posedge i_core_clk);
      s = s | o_wdt_reset;
    end
    cmp("no_reset", 16'(s), 16'h0000);
  endtask

  // tick phase is unknown, so the first tick may land up to 200 early
  task automatic pulse_in(input int lo, hi);
    int n;
    n = 0;
    while (o_wdt_reset !== 1'b1 && n < hi) begin
      @(posedge i_core_clk);
      #1 n++;
    end
    cmp("reset_time", 16'(n >= lo && n < hi), 16'h0001);
    @(posedge i_core_clk);
    #1 cmp("reset_len", 16'(o_wdt_reset), 16'h0000);
  endtask

  initial begin
    rst(1'b0, 1'b0);
    rd(CTL_OFF, 8'h00);
    cmp("enabled", 16'(o_enabled), 16'h0000);
    wr(CTL_OFF, 8'hE8);
    rd(CTL_OFF, 8'h08);
    wr(CTL_OFF, 8'h0F);
    rd(CTL_OFF, 8'h08);
    wr(CTL_OFF, 8'h10);
    wr(CTL_OFF, 8'h00);
    rd(CTL_OFF, 8'h08);
    wr(CTL_OFF, 8'h18);
    rd(CTL_OFF, 8'h18);
    // first cycle after the window: the clear must be refused
    @(posedge i_core_clk);
    wr(CTL_OFF, 8'h00);
    rd(CTL_OFF, 8'h08);
    wr(CTL_OFF, 8'h18);
    repeat (2) @(posedge i_core_clk);
    wr(CTL_OFF, 8'h02);
    rd(CTL_OFF, 8'h02);
    cmp("enabled", 16'(o_enabled), 16'h0000);
    wr(CTL_OFF, 8'h18);
    wr(CTL_OFF, 8'h08);
    rd(CTL_OFF, 8'h18);
    repeat (4) begin
      no_pulse(1500);
      @(posedge i_core_clk);
      i_restart <= 1'b1;
      @(posedge i_core_clk);
      i_restart <= 1'b0;
    end
    pulse_in(3000, 3210);
    rd(RSTAT_OFF, 8'h08);
    rd(4'h5, 8'h00);
    wr(RSTAT_OFF, 8'h00);
    rd(RSTAT_OFF, 8'h00);
    wr(CTL_OFF, 8'h18);
    wr(CTL_OFF, 8'h00);
    no_pulse(4000);
    rst(1'b0, 1'b1);
    rd(CTL_OFF, 8'h00);
    wr(CTL_OFF, 8'h05);
    rd(CTL_OFF, 8'h05);
    wr(CTL_OFF, 8'h09);
    pulse_in(6200, 6410);
    rd(RSTAT_OFF, 8'h08);
    @(posedge i_core_clk);
    i_por <= 1'b1;
    @(posedge i_core_clk);
    i_por <= 1'b0;
    rd(RSTAT_OFF, 8'h00);
    rst(1'b1, 1'b0);
    rd(CTL_OFF, 8'h08);
    cmp("enabled", 16'(o_enabled), 16'h0001);
    wr(CTL_OFF, 8'h18);
    wr(CTL_OFF, 8'h01);
    rd(CTL_OFF, 8'h19);
    wr(CTL_OFF, 8'h18);
    wr(CTL_OFF, 8'h00);
    rd(CTL_OFF, 8'h18);
    cmp("enabled", 16'(o_enabled), 16'h0001);
    stop_test();
  end

  // the tests need about 20k cycles; a hang is cut well beyond that
  initial begin
    repeat (40000) @(posedge i_core_clk);
    errors++;
    stop_test();
  end
endmodule

`default_nettype wire
